/* src/rco_div_counter.sv */
// module: free divide counter for the reference clock output
`timescale 1ns/1ps

module rco_div_counter #(
  parameter int CNT_W = 7
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // control
  input  wire logic             clear,
  input  wire logic [CNT_W-1:0] last,
  // state
  output logic      [CNT_W-1:0] count
);

  // ==========================================================
  // counter
  // counts 0..last and wraps; held at zero while cleared so that
  // each start begins a whole period
  always_ff @(posedge aclk)
  begin
    if (!aresetn || clear)
      count <= '0;
    else if (count >= last)
      count <= '0; // also catches a ratio lowered mid-period
    else
      count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
  end

endmodule // rco_div_counter

/* src/rco_pkg.sv */
// package: register map, field layout and types of the reference clock output block
package rco_pkg;

  // ==========================================================
  // register map (byte addresses on the register bus)
  localparam logic [3:0] RCO_ADDR_CONTROL = 4'h0;
  localparam logic [3:0] RCO_ADDR_STATUS  = 4'h4;
  localparam int         RCO_ADDR_W       = 4;

  // ==========================================================
  // control register field positions and widths
  localparam int RCO_EN_BIT   = 7;
  localparam int RCO_DC_LSB   = 3;
  localparam int RCO_DC_W     = 2;
  localparam int RCO_DIV_LSB  = 0;
  localparam int RCO_DIV_W    = 3;
  localparam int RCO_CTRL_W   = 8;

  // divide counter width: the largest ratio is 128, so counts run 0..127
  localparam int RCO_CNT_W    = 7;
  localparam int RCO_RATIO_W  = 8;

  // control register reset value: enable clear, duty 50%, undivided
  localparam logic [7:0] RCO_CTRL_RESET = 8'h10;

  // status register field positions
  localparam int RCO_STAT_RUN_BIT   = 0;
  localparam int RCO_STAT_LEVEL_BIT = 1;
  localparam int RCO_STAT_CNT_LSB   = 8;

  // ==========================================================
  // duty select codes
  localparam logic [1:0] RCO_DUTY_0  = 2'h0;
  localparam logic [1:0] RCO_DUTY_25 = 2'h1;
  localparam logic [1:0] RCO_DUTY_50 = 2'h2;
  localparam logic [1:0] RCO_DUTY_75 = 2'h3;

  // divide select code that passes the system clock through
  localparam logic [2:0] RCO_DIV_NONE = 3'h0;

  // ==========================================================
  // bus answer codes
  localparam logic [1:0] RCO_RESP_OKAY   = 2'h0;
  localparam logic [1:0] RCO_RESP_SLVERR = 2'h2;

  // ==========================================================
  // software view of the control register
  typedef struct packed {
    logic       refclk_on;
    logic [1:0] unused;
    logic [1:0] duty_select;
    logic [2:0] divide_select;
  } rco_ctrl_t;

endpackage

/* src/rco_refclk_out.sv */
// module: reference clock output block with AXI4-Lite control register
`timescale 1ns/1ps
//
// Functional notes
// [R01] Output derives only from the system clock; clock changes pass straight through.
// [R02] Setting the enable starts the output with no glitch or runt pulse.
// [R03] Clearing the enable stops the output at once, mid-period.
// [R04] Divide select bits 2..0: 000 undivided, 001..111 divide by 2..128.
// [R05] Duty select bits 4..3: 11 75%, 10 50%, 01 25%, 00 constant low.
// [R06] Duty applies only for ratios of two or more; undivided follows clock.
// [R07] Divider and duty may change while enabled; glitches then allowed.
// [R08] Upper duty bit resets to one, giving 50% duty after reset.
// [R09] When the clock stops for sleep, outputs hold their present level.
// [R10] Bit 7 is the enable, one runs, zero stops, resets to zero.
// [R11] Generated clock also feeds other peripherals such as the carrier modulator.
// [R12] Disabled output is low; enabling restarts the divide counter from zero.

module rco_refclk_out (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // clock outputs
  output logic             refclk_out_pin,
  output logic             refclk_carrier
);

  // ==========================================================
  // declarations
  rco_pkg::rco_ctrl_t             ctrl_reg;
  logic                           aw_held_reg;
  logic [rco_pkg::RCO_ADDR_W-1:0] aw_addr_reg;
  logic                           w_held_reg;
  logic [31:0]                    w_data_reg;
  logic [3:0]                     w_strb_reg;
  logic                           bvalid_reg;
  logic [1:0]                     bresp_reg;
  logic                           rvalid_reg;
  logic [1:0]                     rresp_reg;
  logic [31:0]                    rdata_reg;
  logic                           wr_fire;
  logic                           rd_fire;
  logic                           run_low_reg;
  logic                           div_phase_reg;
  logic [rco_pkg::RCO_CNT_W-1:0]  count;
  logic [rco_pkg::RCO_CNT_W-1:0]  last_count;
  logic [rco_pkg::RCO_RATIO_W-1:0] high_count;
  logic                           undivided;
  logic [31:0]                    status_word;
  logic [31:0]                    ctrl_word;
  logic                           refclk;

  // ==========================================================
  // decode helpers

  // byte address to register hit; only the low four address bits are decoded, all of them
  function automatic logic addr_is(input logic [rco_pkg::RCO_ADDR_W-1:0] a,
                                   input logic [rco_pkg::RCO_ADDR_W-1:0] ref_a);
    addr_is = (a == ref_a);
  endfunction

  // high time in system clocks for a divide code and duty code
  function automatic logic [rco_pkg::RCO_RATIO_W-1:0] high_of(
    input logic [rco_pkg::RCO_DIV_W-1:0] div,
    input logic [rco_pkg::RCO_DC_W-1:0]  dc);
    logic [rco_pkg::RCO_RATIO_W-1:0] ratio;
    logic [rco_pkg::RCO_RATIO_W-1:0] h;
    ratio = 8'h01 << div;
    unique case (dc)
      rco_pkg::RCO_DUTY_0:  h = 8'h00;                    // [R05]
      rco_pkg::RCO_DUTY_25: h = ratio >> 2;               // [R05]
      rco_pkg::RCO_DUTY_50: h = ratio >> 1;               // [R05]
      rco_pkg::RCO_DUTY_75: h = ratio - (ratio >> 2);     // [R05]
    endcase
    // ratio 2 cannot show a quarter: keep at least one high and one low clock
    if (dc != rco_pkg::RCO_DUTY_0 && h == 8'h00)
      h = 8'h01;
    if (h >= ratio && ratio > 8'h01)
      h = ratio - 8'h01;
    high_of = h;
  endfunction

  // ==========================================================
  // bus handshakes
  // address and data are taken independently and held until the
  // write retires; a second write waits until the answer is taken
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  assign rd_fire = s_axi_arvalid && !rvalid_reg;

  // write address capture
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr[rco_pkg::RCO_ADDR_W-1:0];
    end
    else if (wr_fire)
      aw_held_reg <= 1'b0;
  end

  // write data capture
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end
    else if (wr_fire)
      w_held_reg <= 1'b0;
  end

  // write response; status is read-only, so a write there is refused
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= rco_pkg::RCO_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= addr_is(aw_addr_reg, rco_pkg::RCO_ADDR_CONTROL)
                    ? rco_pkg::RCO_RESP_OKAY : rco_pkg::RCO_RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_reg <= 1'b0;
  end

  // ==========================================================
  // control register
  // only byte lane 0 carries bits; bits 6..5 stay zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl_reg <= rco_pkg::rco_ctrl_t'(rco_pkg::RCO_CTRL_RESET); // [R08] [R10]
    else if (wr_fire && w_strb_reg[0]
             && addr_is(aw_addr_reg, rco_pkg::RCO_ADDR_CONTROL))
    begin
      // taken whether enabled or not; mid-run changes may glitch
      ctrl_reg.refclk_on     <= w_data_reg[rco_pkg::RCO_EN_BIT];             // [R10] [R07]
      ctrl_reg.unused        <= 2'h0;
      ctrl_reg.duty_select   <= w_data_reg[rco_pkg::RCO_DC_LSB +: rco_pkg::RCO_DC_W];   // [R05]
      ctrl_reg.divide_select <= w_data_reg[rco_pkg::RCO_DIV_LSB +: rco_pkg::RCO_DIV_W]; // [R04]
    end
  end

  // ==========================================================
  // read path
  assign ctrl_word = {24'h000000, ctrl_reg};

  always_comb
  begin
    status_word = 32'h00000000;
    status_word[rco_pkg::RCO_STAT_RUN_BIT]   = run_low_reg;
    status_word[rco_pkg::RCO_STAT_LEVEL_BIT] = div_phase_reg;
    status_word[rco_pkg::RCO_STAT_CNT_LSB +: rco_pkg::RCO_CNT_W] = count;
  end

  // read answer one clock after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= rco_pkg::RCO_RESP_OKAY;
      rdata_reg  <= '0;
    end
    else if (rd_fire)
    begin
      rvalid_reg <= 1'b1;
      if (addr_is(s_axi_araddr[rco_pkg::RCO_ADDR_W-1:0], rco_pkg::RCO_ADDR_CONTROL))
      begin
        rresp_reg <= rco_pkg::RCO_RESP_OKAY;
        rdata_reg <= ctrl_word;
      end
      else if (addr_is(s_axi_araddr[rco_pkg::RCO_ADDR_W-1:0], rco_pkg::RCO_ADDR_STATUS))
      begin
        rresp_reg <= rco_pkg::RCO_RESP_OKAY;
        rdata_reg <= status_word;
      end
      else
      begin
        rresp_reg <= rco_pkg::RCO_RESP_SLVERR;
        rdata_reg <= 32'h00000000;
      end
    end
    else if (s_axi_rready)
      rvalid_reg <= 1'b0;
  end

  // ==========================================================
  // divider
  assign undivided  = (ctrl_reg.divide_select == rco_pkg::RCO_DIV_NONE);
  assign high_count = high_of(ctrl_reg.divide_select, ctrl_reg.duty_select);
  assign last_count = rco_pkg::RCO_CNT_W'((8'h01 << ctrl_reg.divide_select) - 8'h01); // [R04]

  // counter held at zero while off, so each start is a whole period
  rco_div_counter #(
    .CNT_W (rco_pkg::RCO_CNT_W)
  ) u_div_counter (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clear   (!ctrl_reg.refclk_on), // [R12]
    .last    (last_count),
    .count   (count)
  );

  // divided phase: high for the first high_count clocks of each period
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      div_phase_reg <= 1'b0;
    else
      div_phase_reg <= ctrl_reg.refclk_on && !undivided
                       && ({1'b0, count} < high_count); // [R05] [R06] [R12]
  end

  // ==========================================================
  // undivided gate
  // the enable is retimed on the falling edge so the gate only opens
  // or closes while the system clock is low: no runt high pulse
  always_ff @(negedge aclk)
  begin
    if (!aresetn)
      run_low_reg <= 1'b0;
    else
      run_low_reg <= ctrl_reg.refclk_on; // [R02]
  end

  // ==========================================================
  // output select
  // divided mode gates on the enable itself, so a clear stops the
  // output in the same clock rather than at the end of the period;
  // the undivided path passes the system clock, so any clock switch
  // shows on the pin, and a stopped clock holds every level as is
  always_comb
  begin
    if (undivided)
      refclk = aclk & run_low_reg;                  // [R01] [R06] [R02] [R09]
    else
      refclk = ctrl_reg.refclk_on & div_phase_reg;  // [R03] [R12] [R09]
  end

  // same clock to the pin and to on-chip users
  assign refclk_out_pin = refclk;
  assign refclk_carrier = refclk; // [R11]

endmodule // rco_refclk_out

/* verification/rco_refclk_checker.sv */
// checker: bus handshake and clock output assertions
`timescale 1ns/1ps

module rco_refclk_checker (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic [31:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // clock outputs
  input wire logic        refclk_out_pin,
  input wire logic        refclk_carrier
);
  // both halves of a write taken at one edge
  wire wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire rd_take = s_axi_arvalid && s_axi_arready;

  // ==========================================================
  // assertions, all in the one aclk domain
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_carrier_copy: assert property (refclk_carrier == refclk_out_pin)
    else $error("carrier copy differs from pin");
  chk_write_okay: assert property (wr_take && s_axi_awaddr[3:0] == 4'h0
    |-> ##2 s_axi_bvalid && s_axi_bresp == rco_pkg::RCO_RESP_OKAY)
    else $error("control write not answered okay");
  chk_status_refused: assert property (wr_take && s_axi_awaddr[3:0] == 4'h4
    |-> ##2 s_axi_bvalid && s_axi_bresp == rco_pkg::RCO_RESP_SLVERR)
    else $error("status write not refused");
  chk_read_answer: assert property (rd_take |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  chk_unmapped_read: assert property (rd_take && s_axi_araddr[3:0] == 4'h8
    |=> s_axi_rresp == rco_pkg::RCO_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  chk_b_taken: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer outlived its taking");
  chk_r_taken: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer outlived its taking");
  chk_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while answer pending");
  chk_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answer pending");
  // main scenarios reached
  cov_write: cover property (wr_take);
  cov_read_err: cover property (rd_take && s_axi_araddr[3:0] == 4'h8);
  cov_pin_rise: cover property ($rose(refclk_out_pin));
endmodule // rco_refclk_checker

bind rco_refclk_out rco_refclk_checker i_rco_refclk_checker (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .refclk_out_pin(refclk_out_pin),
  .refclk_carrier(refclk_carrier)
);

/* verification/rco_refclk_out_test.sv */
// testbench: register bus tests and output clock measurements
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
  $display("mismatch at %0t: got %h expected %h", $time, a, e); end end

module rco_refclk_out_test;
  // clock, reset and bus drive
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        run = 1'b1;
  logic        clr = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0;
  logic [3:0]  wstrb = '0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  // design answers
  logic        awready, wready, bvalid, arready, rvalid, pin, carrier, lvl;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic [7:0]  hi_cnt, rise_cnt, cfg;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          ratio, hi;

  // clock stands still while run is low, as in sleep
  always #25 aclk = run ? ~aclk : aclk;

  rco_refclk_out i_rco_refclk_out (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .refclk_out_pin(pin),
    .refclk_carrier(carrier));
  rco_refclk_sink i_rco_refclk_sink (
    .aclk(aclk), .clr(clr), .refclk_out_pin(pin), .hi_cnt(hi_cnt), .rise_cnt(rise_cnt));

  // ==========================================================
  // bus tasks; each channel is released at the edge that takes it
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rdr(input logic [31:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // clear the sink, then let it tally len clocks
  task automatic window(input int len);
    @(posedge aclk);
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    repeat (len) @(posedge aclk);
    #1;
  endtask

  task automatic close_out;
    $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(32'h0);
    `CHK(rd, 32'h10)
    wr(32'h0, 32'hff, 4'h0);
    rdr(32'h0);
    `CHK(rd[7], 1'b0)
    wr(32'h4, 32'h80, 4'hf);
    wr(32'h8, 32'h80, 4'hf);
    `CHK(resp, rco_pkg::RCO_RESP_SLVERR)
    rdr(32'h8);
    `CHK({resp, rd}, {rco_pkg::RCO_RESP_SLVERR, 32'h0})
    // every divided ratio and duty, changed while running; unused bits must drop
    for (int d = 1; d < 8; d++)
      for (int c = 0; c < 4; c++)
      begin
        cfg = {1'b1, 2'b00, 2'(c), 3'(d)};
        wr(32'h0, 32'hffff_ff60 | cfg, 4'h1);
        rdr(32'h0);
        `CHK(rd, {24'h0, cfg})
        ratio = 1 << d;
        hi = (c == 0) ? 0 : (d == 1) ? 1 : c * ratio / 4;
        repeat (140) @(posedge aclk);
        window(ratio);
        `CHK(hi_cnt, 8'(hi))
        `CHK(rise_cnt, (c == 0) ? 8'h0 : 8'h1)
      end
    // stop in the middle of a long high phase
    wr(32'h0, 32'h97, 4'h1);
    repeat (140) if (pin !== 1'b1) @(posedge aclk);
    repeat (8) @(posedge aclk);
    wr(32'h0, 32'h17, 4'h1);
    #1;
    `CHK(pin, 1'b0)
    window(200);
    `CHK(hi_cnt, 8'h0)
    // undivided with duty 00 still follows the clock
    wr(32'h0, 32'h80, 4'h1);
    repeat (4) @(posedge aclk);
    repeat (4)
    begin
      @(posedge aclk);
      #10;
      `CHK(pin, 1'b1)
      #25;
      `CHK(pin, 1'b0)
    end
    // clock halted in a divided mode: the pin keeps its level
    wr(32'h0, 32'h0, 4'h1);
    wr(32'h0, 32'h93, 4'h1);
    repeat (21) @(posedge aclk);
    #1;
    lvl = pin;
    run = 1'b0;
    #1000;
    `CHK(pin, lvl)
    run = 1'b1;
    window(8);
    `CHK(hi_cnt, 8'h4)
    close_out;
  end

  // watchdog: tests take about 6000 clocks, limit is 40000 clocks
  initial
  begin
    #2000000;
    miscompares++;
    close_out;
  end
endmodule // rco_refclk_out_test

/* verification/rco_refclk_sink.sv */
// partner: sink on the reference clock pin that tallies high samples and rises
`timescale 1ns/1ps

module rco_refclk_sink (
  // clock and control
  input  wire logic       aclk,
  input  wire logic       clr,
  // observed pin
  input  wire logic       refclk_out_pin,
  // tallies
  output logic      [7:0] hi_cnt,
  output logic      [7:0] rise_cnt
);
  logic last_lvl = 1'b0;

  // ==========================================================
  // a window of one full period holds one rise, or none when the duty is 00
  always @(posedge aclk)
  begin
    last_lvl <= refclk_out_pin;
    if (clr)
    begin
      hi_cnt   <= 8'h00;
      rise_cnt <= 8'h00;
    end
    else
    begin
      hi_cnt   <= hi_cnt + 8'(refclk_out_pin);
      rise_cnt <= rise_cnt + 8'(refclk_out_pin && !last_lvl);
    end
  end
endmodule // rco_refclk_sink
